/* rtl/grc_params.svh */
// Offsets, field positions, reset values and latencies of the global bank
`ifndef GRC_PARAMS_SVH
`define GRC_PARAMS_SVH

// Register port widths
`define GRC_ADDR_W            13
`define GRC_DATA_W            8

// Register offsets
`define GRC_ADDR_SOFT_RESET   13'h0000
`define GRC_ADDR_REQ_MODE     13'h0001
`define GRC_ADDR_TUNE_SLIP    13'h0002

// Reset values
`define GRC_RST_SOFT_RESET    8'h00
`define GRC_RST_REQ_MODE      8'h00
`define GRC_RST_TUNE_SLIP     8'h00
`define GRC_RD_UNMAPPED       8'h00

// Soft reset register fields
`define GRC_BIT_SOFT_RESET    0

// Request and mode register fields
`define GRC_BIT_RESEED        7
`define GRC_BIT_DIST_NOISE    6
`define GRC_BIT_LOOP_NOISE    5
`define GRC_BIT_HOLDOVER      4
`define GRC_BIT_MUTE          3
`define GRC_BIT_PULSE_GEN     2
`define GRC_BIT_RESTART       1
`define GRC_BIT_SLEEP         0

// Tune and slip register fields
`define GRC_BIT_AUTOTUNE      2
`define GRC_BIT_SLIP          1

// Resync sequencer done code
`define GRC_SEQ_DONE          4'h2

// Holdover latency in system clock (sys_clk_i) cycles
`define GRC_HOLD_LAT_DEB      6
`define GRC_HOLD_LAT_BYP      2

// Number of edge-sensitive request bits
`define GRC_NUM_EDGE          4

`endif

/* rtl/grc_pkg.sv */
// Types shared by the global request control bank
`include "grc_params.svh"

package grc_pkg;

  // Register access request
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`GRC_ADDR_W-1:0]  addr;
    logic [`GRC_DATA_W-1:0]  wdata;
  } grc_reg_req_s;

  // Level controls to the analog and divider logic
  typedef struct packed {
    logic dist_noise_prio;
    logic loop_noise_prio;
    logic mute;
    logic sleep;
    logic div_fsm_restart;
  } grc_ctrl_s;

  // One-cycle request pulses
  typedef struct packed {
    logic soft_reset;
    logic reseed;
    logic pulse_gen;
    logic autotune;
    logic slip;
  } grc_pulse_s;

endpackage : grc_pkg

/* rtl/grc_edge_pulse.sv */
// Rising-edge detector giving one-cycle pulses per request bit
`timescale 1ns/1ps
`include "grc_params.svh"

module grc_edge_pulse
#(
  parameter int W = `GRC_NUM_EDGE
)
(
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire logic          clr_i,
  input  wire logic [W-1:0]  level_i,
  input  wire logic [W-1:0]  accept_i,
  output logic      [W-1:0]  pulse_o
);

  logic [W-1:0] prev_ff;
  logic [W-1:0] pulse_ff;
  wire  [W-1:0] nxt_pulse;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // Pulse only on a zero-to-one change that is accepted
      assign nxt_pulse[i] = level_i[i] & ~prev_ff[i] & accept_i[i];
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_ff  <= '0;
      pulse_ff <= '0;
    end
    else if (clr_i)
    begin
      prev_ff  <= '0;
      pulse_ff <= '0;
    end
    else
    begin
      prev_ff  <= level_i;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse_o = pulse_ff;

endmodule : grc_edge_pulse

/* rtl/grc_holdover_deb.sv */
// Holdover request filter with selectable debounce or bypass latency
`timescale 1ns/1ps
`include "grc_params.svh"

module grc_holdover_deb
(
  input  wire logic  sys_clk_i,
  input  wire logic  rst_i,
  input  wire logic  clr_i,
  input  wire logic  force_i,
  input  wire logic  bypass_i,
  output logic       holdover_o
);

  localparam int DEPTH = `GRC_HOLD_LAT_DEB - 1;

  logic [DEPTH-1:0] samp_ff;
  logic             hold_ff;
  wire              all_one;
  wire              all_zero;
  wire              nxt_hold;

  // Debounced: level must be stable over all samples
  assign all_one  = &samp_ff;
  assign all_zero = ~|samp_ff;
  // Bypass takes the first sample only
  assign nxt_hold = bypass_i ? samp_ff[0] :
                    all_one  ? 1'b1 :
                    all_zero ? 1'b0 : hold_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      samp_ff <= '0;
      hold_ff <= 1'b0;
    end
    else if (clr_i)
    begin
      samp_ff <= '0;
      hold_ff <= 1'b0;
    end
    else
    begin
      samp_ff <= {samp_ff[DEPTH-2:0], force_i};
      hold_ff <= nxt_hold;
    end
  end

  assign holdover_o = hold_ff;

endmodule : grc_holdover_deb

/* rtl/grc_bank.sv */
// Global request and mode control register bank
// Functional notes
// - Soft reset returns everything but the held read data to defaults
// - Reseed bit asks sequencer to reseed dividers
// - Reseed acts only on rising edge
// - Reseed accepted only in sequencer done state
// - Bit 6 selects distribution noise priority
// - Bit 5 selects loop noise priority
// - Bit 4 or input pin forces holdover
// - Holdover request passes through a debouncer
// - Debounced holdover reached after six cycles
// - Bypassed holdover reached after two cycles
// - Bit 3 mutes drivers, dividers keep running
// - Bit 2 requests a pulse-generator stream
// - Bit 1 restarts dividers, keeps configuration
// - Bit 0 forces sleep of loops and buffers
// - Autotune bit retriggers synthesizer-loop tuning
// - Slip bit requests slip from divider channels
// - Slip request acts on its rising edge
`timescale 1ns/1ps
`include "grc_params.svh"

module grc_bank
(
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire grc_pkg::grc_reg_req_s    reg_req_i,
  output logic [`GRC_DATA_W-1:0]        rd_data_o,
  output logic                          rd_valid_o,
  input  wire logic [3:0]               resync_sequencer_state_i,
  input  wire logic                     general_purpose_input_i,
  input  wire logic                     debounce_bypass_i,
  output grc_pkg::grc_ctrl_s            ctrl_o,
  output grc_pkg::grc_pulse_s           pulse_o,
  output logic                          holdover_o
);

  // Address compare used by write and read decode
  function automatic logic addr_hit
  (
    input logic [`GRC_ADDR_W-1:0] addr,
    input logic [`GRC_ADDR_W-1:0] target
  );
    addr_hit = (addr == target);
  endfunction : addr_hit

  // Stored registers
  logic [`GRC_DATA_W-1:0]  soft_ff;
  logic [`GRC_DATA_W-1:0]  req_ff;
  logic [`GRC_DATA_W-1:0]  tune_ff;

  // Outputs held in flops
  logic [`GRC_DATA_W-1:0]  rd_data_ff;
  logic                    rd_valid_ff;
  logic                    soft_reset_ff;
  grc_pkg::grc_ctrl_s      ctrl_ff;

  // Next values
  logic [`GRC_DATA_W-1:0]  nxt_soft;
  logic [`GRC_DATA_W-1:0]  nxt_req;
  logic [`GRC_DATA_W-1:0]  nxt_tune;
  logic [`GRC_DATA_W-1:0]  nxt_rd_data;
  grc_pkg::grc_ctrl_s      nxt_ctrl;
  logic [`GRC_DATA_W-1:0]  nxt_rd_hold;
  logic                    nxt_rd_valid;
  logic                    nxt_soft_reset;

  // Address decode
  wire sel_soft;
  wire sel_req;
  wire sel_tune;
  wire wr_soft;
  wire wr_req;
  wire wr_tune;
  wire soft_fire;
  wire rd_take;

  // Submodule links
  wire                        seq_done;
  wire                        hold_force;
  wire [`GRC_NUM_EDGE-1:0]    edge_level;
  wire [`GRC_NUM_EDGE-1:0]    edge_accept;
  wire [`GRC_NUM_EDGE-1:0]    edge_pulse;
  wire                        hold_level;
  wire                        lvl_reseed;
  wire                        lvl_pulse_gen;
  wire                        lvl_autotune;
  wire                        lvl_slip;

  assign sel_soft = addr_hit(reg_req_i.addr, `GRC_ADDR_SOFT_RESET);
  assign sel_req  = addr_hit(reg_req_i.addr, `GRC_ADDR_REQ_MODE);
  assign sel_tune = addr_hit(reg_req_i.addr, `GRC_ADDR_TUNE_SLIP);

  assign wr_soft = reg_req_i.wr & sel_soft;
  assign wr_req  = reg_req_i.wr & sel_req;
  assign wr_tune = reg_req_i.wr & sel_tune;
  assign rd_take = reg_req_i.rd;

  // Writing one to the soft reset bit clears all three registers, the edge detector and the holdover filter
  assign soft_fire = wr_soft & reg_req_i.wdata[`GRC_BIT_SOFT_RESET];

  // Full bytes stored so reserved bits read back
  assign nxt_soft = soft_fire ? `GRC_RST_SOFT_RESET :
                    wr_soft   ? reg_req_i.wdata :
                    soft_ff;

  assign nxt_req  = soft_fire ? `GRC_RST_REQ_MODE :
                    wr_req    ? reg_req_i.wdata :
                    req_ff;

  assign nxt_tune = soft_fire ? `GRC_RST_TUNE_SLIP :
                    wr_tune   ? reg_req_i.wdata :
                    tune_ff;

  // Read data mux, unmapped addresses read zero
  always_comb
  begin
    if (sel_soft)
    begin
      nxt_rd_data = soft_ff;
    end
    else if (sel_req)
    begin
      nxt_rd_data = req_ff;
    end
    else if (sel_tune)
    begin
      nxt_rd_data = tune_ff;
    end
    else
    begin
      nxt_rd_data = `GRC_RD_UNMAPPED;
    end
  end

  // Level controls taken from the request register
  always_comb
  begin
    nxt_ctrl.dist_noise_prio = req_ff[`GRC_BIT_DIST_NOISE];
    nxt_ctrl.loop_noise_prio = req_ff[`GRC_BIT_LOOP_NOISE];
    nxt_ctrl.mute            = req_ff[`GRC_BIT_MUTE];
    nxt_ctrl.sleep           = req_ff[`GRC_BIT_SLEEP];
    // Restart holds dividers and state machines, registers untouched
    nxt_ctrl.div_fsm_restart = req_ff[`GRC_BIT_RESTART]
                             | soft_reset_ff;
  end

  // Soft reset register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      soft_ff <= `GRC_RST_SOFT_RESET;
    end
    else
    begin
      soft_ff <= nxt_soft;
    end
  end

  // Request and mode register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_ff <= `GRC_RST_REQ_MODE;
    end
    else
    begin
      req_ff <= nxt_req;
    end
  end

  // Tune and slip register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tune_ff <= `GRC_RST_TUNE_SLIP;
    end
    else
    begin
      tune_ff <= nxt_tune;
    end
  end

  // Read data is held between reads
  assign nxt_rd_hold  = rd_take ? nxt_rd_data : rd_data_ff;
  assign nxt_rd_valid = rd_take;

  // Read data port
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_data_ff <= `GRC_RD_UNMAPPED;
    end
    else
    begin
      rd_data_ff <= nxt_rd_hold;
    end
  end

  // Read valid pulse
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // Soft reset pulse follows the write by one cycle
  assign nxt_soft_reset = soft_fire;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      soft_reset_ff <= 1'b0;
    end
    else
    begin
      soft_reset_ff <= nxt_soft_reset;
    end
  end

  // Level control outputs
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Sequencer must report done before a reseed is taken
  assign seq_done = (resync_sequencer_state_i == `GRC_SEQ_DONE);

  // Edge request bits: slip, autotune, pulse generator, reseed
  assign lvl_reseed    = req_ff[`GRC_BIT_RESEED];
  assign lvl_pulse_gen = req_ff[`GRC_BIT_PULSE_GEN];
  assign lvl_autotune  = tune_ff[`GRC_BIT_AUTOTUNE];
  assign lvl_slip      = tune_ff[`GRC_BIT_SLIP];

  // Packed in detector bit order
  assign edge_level = {lvl_slip,
                       lvl_autotune,
                       lvl_pulse_gen,
                       lvl_reseed};

  assign edge_accept = {1'b1,
                        1'b1,
                        1'b1,
                        seq_done};

  grc_edge_pulse
  #(
    .W         (`GRC_NUM_EDGE)
  )
  u_edge
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (soft_reset_ff),
    .level_i   (edge_level),
    .accept_i  (edge_accept),
    .pulse_o   (edge_pulse)
  );

  // Holdover forced by register bit or input pin
  assign hold_force = req_ff[`GRC_BIT_HOLDOVER]
                    | general_purpose_input_i;

  grc_holdover_deb u_hold
  (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .clr_i      (soft_reset_ff),
    .force_i    (hold_force),
    .bypass_i   (debounce_bypass_i),
    .holdover_o (hold_level)
  );

  // Output assembly, every field from a flop
  assign rd_data_o  = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign ctrl_o     = ctrl_ff;
  assign holdover_o = hold_level;

  assign pulse_o.soft_reset = soft_reset_ff;
  assign pulse_o.reseed     = edge_pulse[0];
  assign pulse_o.pulse_gen  = edge_pulse[1];
  assign pulse_o.autotune   = edge_pulse[2];
  assign pulse_o.slip       = edge_pulse[3];

endmodule : grc_bank

/* tb/grc_bank_asserts.sv */
// Assertions on the ports of the global request control bank
`timescale 1ns/1ps
`include "grc_params.svh"

module grc_bank_asserts
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire grc_pkg::grc_reg_req_s reg_req_i,
  input  wire logic [`GRC_DATA_W-1:0] rd_data_o,
  input  wire logic                  rd_valid_o,
  input  wire logic [3:0]            resync_sequencer_state_i,
  input  wire logic                  general_purpose_input_i,
  input  wire logic                  debounce_bypass_i,
  input  wire grc_pkg::grc_ctrl_s    ctrl_o,
  input  wire grc_pkg::grc_pulse_s   pulse_o,
  input  wire logic                  holdover_o
);
  logic       hb_ff;
  wire  [7:0] wd  = reg_req_i.wdata;
  wire        b   = debounce_bypass_i;
  wire        wr0 = reg_req_i.wr && reg_req_i.addr == `GRC_ADDR_SOFT_RESET;
  wire        wr1 = reg_req_i.wr && reg_req_i.addr == `GRC_ADDR_REQ_MODE;
  wire        wr2 = reg_req_i.wr && reg_req_i.addr == `GRC_ADDR_TUNE_SLIP;
  wire        rd1 = reg_req_i.rd && !reg_req_i.wr &&
                    reg_req_i.addr == `GRC_ADDR_REQ_MODE;
  wire        frc = hb_ff | general_purpose_input_i;

  // Stored holdover bit, mirrored for the force term
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      hb_ff <= 1'b0;
    else if (wr1)
      hb_ff <= wd[4];
    else if (wr0 && wd[0])
      hb_ff <= 1'b0;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_byp;
    (!frc && b) ##1 (frc && b);
  endsequence
  sequence s_deb;
    (!frc && !b)[*6] ##1 (frc && !b)[*5];
  endsequence
  sequence s_soft_wr;
    wr0 && wd[0];
  endsequence
  sequence s_soft_out;
    pulse_o.soft_reset ##1 (ctrl_o[4:1] == 4'h0 && ctrl_o.div_fsm_restart);
  endsequence
  sequence s_rd;
    wr1 ##1 !reg_req_i.wr ##1 rd1;
  endsequence
  property p_ctl(logic c, logic d);
    wr1 |-> ##2 c == $past(d, 2);
  endproperty
  property p_restart;
    wr1 && wd[1] |-> ##2 ctrl_o.div_fsm_restart;
  endproperty
  property p_reseed;
    pulse_o.reseed |-> $past(resync_sequencer_state_i) == `GRC_SEQ_DONE;
  endproperty
  property p_once;
    (pulse_o & $past(pulse_o)) == 5'h00;
  endproperty
  property p_slip;
    pulse_o.slip |-> $past(wr2, 2) && $past(wd[1], 2);
  endproperty
  property p_soft;
    s_soft_wr |=> s_soft_out;
  endproperty
  property p_rd_back;
    s_rd |=> rd_valid_o && rd_data_o == $past(wd, 3);
  endproperty
  property p_byp;
    s_byp |=> !holdover_o ##1 holdover_o;
  endproperty
  property p_deb;
    s_deb |-> ##1 !holdover_o ##1 holdover_o;
  endproperty

  a_dist_mode: assert property (p_ctl(ctrl_o[4], wd[6]))
    else $error("dist mode wrong");
  a_loop_mode: assert property (p_ctl(ctrl_o[3], wd[5]))
    else $error("loop mode wrong");
  a_mute_level: assert property (p_ctl(ctrl_o[2], wd[3]))
    else $error("mute wrong");
  a_sleep_level: assert property (p_ctl(ctrl_o[1], wd[0]))
    else $error("sleep wrong");
  a_restart_set: assert property (p_restart)
    else $error("restart missing");
  a_reseed_gate: assert property (p_reseed)
    else $error("reseed outside done");
  a_pulse_once: assert property (p_once)
    else $error("pulse too long");
  a_slip_edge: assert property (p_slip)
    else $error("slip without write");
  a_soft_seq: assert property (p_soft)
    else $error("soft reset wrong");
  a_rd_back: assert property (p_rd_back)
    else $error("readback wrong");
  a_hold_byp: assert property (p_byp)
    else $error("bypass latency wrong");
  a_hold_deb: assert property (p_deb)
    else $error("debounce latency wrong");
endmodule : grc_bank_asserts

bind grc_bank grc_bank_asserts i_grc_bank_asserts
(
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .resync_sequencer_state_i(resync_sequencer_state_i),
  .general_purpose_input_i(general_purpose_input_i),
  .debounce_bypass_i(debounce_bypass_i), .ctrl_o(ctrl_o),
  .pulse_o(pulse_o), .holdover_o(holdover_o)
);

/* tb/tb.sv */
// Self-checking bench for the global request control bank
`timescale 1ns/1ps
`include "grc_params.svh"

module tb;
  logic                  sys_clk_i = 1'b0;
  logic                  rst_i     = 1'b1;
  grc_pkg::grc_reg_req_s req       = '0;
  logic [3:0]            st        = 4'h2;
  logic                  general_purpose_input       = 1'b0;
  logic                  byp       = 1'b0;
  logic [7:0]            rdat;
  logic                  rval;
  grc_pkg::grc_ctrl_s    ctrl;
  grc_pkg::grc_pulse_s   pls;
  logic                  hold;
  logic [7:0]            v;
  int                    err_count       = 0;
  int                    samples_checked = 0;
  // Address, write data, readback, level controls
  logic [33:0] rows [9] = '{
    {13'h0001, 8'h40, 8'h40, 5'h10}, {13'h0001, 8'h20, 8'h20, 5'h08},
    {13'h0001, 8'h08, 8'h08, 5'h04}, {13'h0001, 8'h01, 8'h01, 5'h02},
    {13'h0001, 8'h02, 8'h02, 5'h01}, {13'h0002, 8'hF9, 8'hF9, 5'h01},
    {13'h0001, 8'h00, 8'h00, 5'h00}, {13'h0003, 8'hFF, 8'h00, 5'h00},
    {13'h0000, 8'hFE, 8'hFE, 5'h00}};
  // Address, write data, sequencer state, pulses
  logic [29:0] evs [8] = '{
    {13'h0001, 8'h84, 4'h2, 5'h0C}, {13'h0001, 8'h84, 4'h2, 5'h00},
    {13'h0001, 8'h00, 4'h2, 5'h00}, {13'h0001, 8'h80, 4'h3, 5'h00},
    {13'h0001, 8'h00, 4'h2, 5'h00}, {13'h0001, 8'h80, 4'h2, 5'h08},
    {13'h0002, 8'h06, 4'h2, 5'h03}, {13'h0002, 8'h00, 4'h2, 5'h00}};

  always #5 sys_clk_i = ~sys_clk_i;

  grc_bank i_grc_bank
  (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req),
    .rd_data_o(rdat), .rd_valid_o(rval), .resync_sequencer_state_i(st),
    .general_purpose_input_i(general_purpose_input), .debounce_bypass_i(byp),
    .ctrl_o(ctrl), .pulse_o(pls), .holdover_o(hold)
  );

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [12:0] a);
    @(posedge sys_clk_i);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1;
    chk(8'(rval), 8'h01);
    v = rdat;
  endtask : rd

  task automatic wait_hold(input logic lvl, input int n);
    int c;
    c = 0;
    while (hold !== lvl)
    begin
      @(posedge sys_clk_i);
      #1;
      c++;
      if (c > 20)
      begin
        err_count++;
        test_done();
      end
    end
    chk(8'(c), 8'(n));
  endtask : wait_hold

  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    chk(8'(ctrl), 8'h00);
    chk(8'(pls), 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      rd(13'(i));
      chk(v, 8'h00);
    end
    foreach (rows[i])
    begin
      wr(rows[i][33:21], rows[i][20:13]);
      rd(rows[i][33:21]);
      chk(v, rows[i][12:5]);
      chk(8'(ctrl), 8'(rows[i][4:0]));
    end
    foreach (evs[i])
    begin
      @(posedge sys_clk_i);
      st <= evs[i][8:5];
      wr(evs[i][29:17], evs[i][16:9]);
      @(posedge sys_clk_i);
      #1;
      chk(8'(pls), 8'(evs[i][4:0]));
      @(posedge sys_clk_i);
      #1;
      chk(8'(pls), 8'h00);
    end
    @(posedge sys_clk_i);
    general_purpose_input <= 1'b1;
    wait_hold(1'b1, 6);
    @(posedge sys_clk_i);
    general_purpose_input <= 1'b0;
    wait_hold(1'b0, 6);
    @(posedge sys_clk_i);
    general_purpose_input <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    general_purpose_input <= 1'b0;
    v = 8'h00;
    repeat (8)
    begin
      @(posedge sys_clk_i);
      #1;
      v = v | 8'(hold);
    end
    chk(v, 8'h00);
    @(posedge sys_clk_i);
    byp <= 1'b1;
    wr(13'h0001, 8'h10);
    wait_hold(1'b1, 2);
    wr(13'h0001, 8'h00);
    wait_hold(1'b0, 2);
    wr(13'h0001, 8'h6B);
    wr(13'h0002, 8'hF8);
    wr(13'h0000, 8'h01);
    #1;
    chk(8'(pls), 8'h10);
    @(posedge sys_clk_i);
    #1;
    chk(8'(ctrl), 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      rd(13'(i));
      chk(v, 8'h00);
    end
    test_done();
  end
endmodule : tb
